// ==== pkg/arsq_pkg.sv ====
// Constants and the state type shared by the auto-reclose sequencer files.
package arsq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int MAX_SHOTS = 6;
  localparam int INIT_SLOTS = 4;
  localparam int SHOT_W = 3;
  localparam int DT_W = 16;
  localparam int TIME_W = 22;
  localparam int CNT_W = 16;
  localparam int HOUR_W = 8;
  localparam logic [SHOT_W-1:0] SHOT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Pin vector bit positions
  // ----------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int PIN_BKR = 0;
  localparam int PIN_BLK0 = 1;
  localparam int PIN_BLK1 = 2;
  localparam int PIN_LOCK = 3;
  localparam int PIN_INCR = 4;
  localparam int PIN_RESET = 5;
  localparam int PIN_BRDY = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
  localparam int BKR_SUP_MS = 200;
  localparam int HOUR_MS = 3600000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STANDBY,
    ST_MAN_BLOCK,
    ST_READY,
    ST_RUN_FAULT,
    ST_WAIT_OPEN,
    ST_DEAD,
    ST_RECLOSING,
    ST_RUN2READY,
    ST_BLOCKED,
    ST_LOCKOUT,
    ST_LOR
  } arsq_state_type;

endpackage

// ==== core/arsq_timer.sv ====
// Millisecond down-counter used for the sequencer's timers.
`timescale 1ns/1ps
`default_nettype none
module arsq_timer #(
  parameter int W = 22
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic tick,
  // Status
  output logic done
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A load always wins over a pending tick so a restart is never shortened.
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (tick && count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);

endmodule
`default_nettype wire

// ==== core/arsq_core.sv ====
// Auto-reclose sequencer: states, shots, timers, limits and counters.
`timescale 1ns/1ps
`default_nettype none
module arsq_core
  import arsq_pkg::*;
#(
  parameter int N_FUNC = 16,
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int HOUR_LEN_MS = HOUR_MS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic function_active,
  input wire logic breaker_configured,
  input wire logic [SHOT_W-1:0] shots_cfg,
  input wire logic [HOUR_W-1:0] max_cycles_per_hour,
  input wire logic [DT_W-1:0] dead_time_ms [1:MAX_SHOTS],
  input wire logic [DT_W-1:0] t_manual_block_ms,
  input wire logic [DT_W-1:0] t_fault_ms,
  input wire logic [DT_W-1:0] t_close_sup_ms,
  input wire logic [DT_W-1:0] t_run2ready_ms,
  input wire logic [DT_W-1:0] t_lockout_reset_ms,
  input wire logic [$clog2(N_FUNC)-1:0] init_sel_idx [0:MAX_SHOTS][0:INIT_SLOTS-1],
  input wire logic [INIT_SLOTS-1:0] init_sel_en [0:MAX_SHOTS],
  input wire logic [N_FUNC-1:0] block_func_mask,
  input wire logic ext_block_enable,
  input wire logic ext_lock_enable,
  input wire logic ext_incr_enable,
  input wire logic ext_reset_enable,
  // Protective functions
  input wire logic [N_FUNC-1:0] prot_trip,
  // Pins
  input wire logic breaker_closed_in,
  input wire logic breaker_ready_in,
  input wire logic [1:0] external_block_inputs,
  input wire logic ext_lock_in,
  input wire logic ext_incr_in,
  input wire logic ext_reset_in,
  // Outputs
  output arsq_state_type state_out,
  output logic [SHOT_W-1:0] shot_out,
  output logic close_cmd,
  output logic result_ok,
  output logic result_fail,
  output logic [HOUR_W-1:0] hour_count,
  output logic [CNT_W-1:0] count_total,
  output logic [CNT_W-1:0] count_ok,
  output logic [CNT_W-1:0] count_fail
);

  localparam int DIV_W = $clog2(TICK_DIV);

  // ----------------------------------------------------------------
  // Pin synchronisers and filter
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, pin_reg, prev_reg;
  logic [PIN_W-1:0] pin_next;

  assign pin_raw = {breaker_ready_in, ext_reset_in, ext_incr_in, ext_lock_in,
                    external_block_inputs, breaker_closed_in};

  // A pin only changes once the second and third stages agree.
  always_comb begin
    pin_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & pin_reg);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
      prev_reg <= pin_reg;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_reg, div_next;
  logic tick;

  assign tick = (div_reg == DIV_W'(TICK_DIV - 1));

  always_comb begin
    div_next = tick ? '0 : div_reg + DIV_W'(1);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  arsq_state_type state_reg, state_next;
  logic [SHOT_W-1:0] shot_reg, shot_next, shots_lim;
  logic [INIT_SLOTS-1:0] init_hit;
  logic bkr_closed, bkr_ready, ext_blk, ext_lock, incr_pulse, reset_pulse;
  logic block_any, enabled, initiate, gen_trip, locked;

  assign bkr_closed = pin_reg[PIN_BKR];
  assign bkr_ready = pin_reg[PIN_BRDY];
  assign ext_blk = ext_block_enable && (pin_reg[PIN_BLK0] || pin_reg[PIN_BLK1]);
  assign ext_lock = ext_lock_enable && pin_reg[PIN_LOCK];
  assign incr_pulse = ext_incr_enable && pin_reg[PIN_INCR] && !prev_reg[PIN_INCR];
  assign reset_pulse = ext_reset_enable && pin_reg[PIN_RESET] && !prev_reg[PIN_RESET];
  assign block_any = ext_blk || |(prot_trip & block_func_mask);
  assign enabled = function_active && breaker_configured;
  assign gen_trip = |prot_trip;
  assign locked = (state_reg == ST_LOCKOUT) || (state_reg == ST_LOR);
  assign shots_lim = (shots_cfg > SHOT_W'(MAX_SHOTS)) ? SHOT_W'(MAX_SHOTS) : shots_cfg;

  // The initiate set follows the shot now running, shot zero included.
  for (genvar k = 0; k < INIT_SLOTS; k++) begin : g_init
    assign init_hit[k] = init_sel_en[shot_reg][k] && prot_trip[init_sel_idx[shot_reg][k]];
  end
  assign initiate = |init_hit;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  logic tmr_load, tmr_done, hour_done;
  logic [TIME_W-1:0] tmr_value;

  arsq_timer #(.W(TIME_W)) u_state_timer (
    .clock(clock),
    .rst(rst),
    .load(tmr_load),
    .load_value(tmr_value),
    .tick(tick),
    .done(tmr_done)
  );

  // Fixed hourly window; the per-hour count restarts at each window end.
  arsq_timer #(.W(TIME_W)) u_hour_timer (
    .clock(clock),
    .rst(rst),
    .load(hour_done),
    .load_value(TIME_W'(HOUR_LEN_MS)),
    .tick(tick),
    .done(hour_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic close_reg, close_next, ok_reg, ok_next, fail_reg, fail_next;
  logic [HOUR_W-1:0] hour_reg, hour_next;
  logic [CNT_W-1:0] tot_reg, tot_next, okc_reg, okc_next, failc_reg, failc_next;

  always_comb begin
    logic go_fail;
    go_fail = 1'b0;
    state_next = state_reg;
    shot_next = shot_reg;
    tmr_load = 1'b0;
    tmr_value = '0;
    close_next = 1'b0;
    ok_next = 1'b0;
    fail_next = 1'b0;
    hour_next = hour_done ? '0 : hour_reg;
    tot_next = tot_reg;
    okc_next = okc_reg;
    failc_next = failc_reg;
    if (!enabled) begin
      state_next = ST_STANDBY;
      shot_next = SHOT_ZERO;
    end else if (block_any && !locked) begin
      state_next = ST_BLOCKED;
      shot_next = SHOT_ZERO;
    end else if (ext_lock && !locked) begin
      state_next = ST_LOCKOUT;
    end else begin
      unique case (state_reg)
        ST_STANDBY: begin
          if (bkr_closed) begin
            state_next = ST_MAN_BLOCK;
            tmr_load = 1'b1;
            tmr_value = TIME_W'(t_manual_block_ms);
          end
        end
        ST_MAN_BLOCK: begin
          shot_next = SHOT_ZERO;
          if (tmr_done) begin
            state_next = bkr_closed ? ST_READY : ST_STANDBY;
          end
        end
        ST_READY: begin
          if (!bkr_closed) begin
            state_next = ST_STANDBY;
          end else if (initiate) begin
            if (hour_next >= max_cycles_per_hour) begin
              state_next = ST_LOCKOUT;
            end else begin
              hour_next = hour_next + HOUR_W'(1);
              state_next = ST_RUN_FAULT;
              tmr_load = 1'b1;
              tmr_value = TIME_W'(t_fault_ms);
            end
          end
        end
        ST_RUN_FAULT: begin
          if (initiate) begin
            state_next = ST_WAIT_OPEN;
            tmr_load = 1'b1;
            tmr_value = TIME_W'(BKR_SUP_MS);
          end else if (tmr_done) begin
            go_fail = 1'b1;
          end
        end
        ST_WAIT_OPEN: begin
          if (!bkr_closed) begin
            if (shot_reg >= shots_lim) begin
              go_fail = 1'b1;
            end else begin
              state_next = ST_DEAD;
              tmr_load = 1'b1;
              tmr_value = TIME_W'(dead_time_ms[shot_reg + SHOT_W'(1)]);
            end
          end else if (tmr_done) begin
            go_fail = 1'b1;
          end
        end
        ST_DEAD: begin
          if (bkr_closed) begin
            go_fail = 1'b1;
          end else if (tmr_done) begin
            if (initiate || gen_trip) begin
              go_fail = 1'b1;
            end else if (bkr_ready) begin
              shot_next = shot_reg + SHOT_W'(1);
              close_next = 1'b1;
              tot_next = tot_reg + CNT_W'(1);
              state_next = ST_RECLOSING;
              tmr_load = 1'b1;
              tmr_value = TIME_W'(t_close_sup_ms);
            end
          end
        end
        ST_RECLOSING: begin
          if (bkr_closed) begin
            state_next = ST_RUN2READY;
            tmr_load = 1'b1;
            tmr_value = TIME_W'(t_run2ready_ms);
          end else if (tmr_done) begin
            go_fail = 1'b1;
          end
        end
        ST_RUN2READY: begin
          if (initiate) begin
            state_next = ST_RUN_FAULT;
            tmr_load = 1'b1;
            tmr_value = TIME_W'(t_fault_ms);
          end else if (tmr_done) begin
            state_next = ST_READY;
            shot_next = SHOT_ZERO;
            ok_next = 1'b1;
            okc_next = okc_reg + CNT_W'(1);
          end
        end
        ST_BLOCKED: begin
          state_next = ST_STANDBY;
        end
        ST_LOCKOUT: begin
          if (reset_pulse) begin
            state_next = ST_LOR;
            tmr_load = 1'b1;
            tmr_value = TIME_W'(t_lockout_reset_ms);
          end
        end
        ST_LOR: begin
          if (tmr_done) begin
            state_next = ST_STANDBY;
            shot_next = SHOT_ZERO;
          end
        end
        default: begin
          state_next = ST_STANDBY;
        end
      endcase
      if (go_fail) begin
        state_next = ST_LOCKOUT;
        fail_next = 1'b1;
        failc_next = failc_reg + CNT_W'(1);
      end
      // Saturates at the configured shot count so a stray pulse cannot overrun.
      if (incr_pulse && !locked && shot_next < shots_lim) begin
        shot_next = shot_next + SHOT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_STANDBY;
      shot_reg <= '0;
      close_reg <= 1'b0;
      ok_reg <= 1'b0;
      fail_reg <= 1'b0;
      hour_reg <= '0;
      tot_reg <= '0;
      okc_reg <= '0;
      failc_reg <= '0;
    end else begin
      state_reg <= state_next;
      shot_reg <= shot_next;
      close_reg <= close_next;
      ok_reg <= ok_next;
      fail_reg <= fail_next;
      hour_reg <= hour_next;
      tot_reg <= tot_next;
      okc_reg <= okc_next;
      failc_reg <= failc_next;
    end
  end

  assign state_out = state_reg;
  assign shot_out = shot_reg;
  assign close_cmd = close_reg;
  assign result_ok = ok_reg;
  assign result_fail = fail_reg;
  assign hour_count = hour_reg;
  assign count_total = tot_reg;
  assign count_ok = okc_reg;
  assign count_fail = failc_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shot_max: assert property (@(posedge clock) disable iff (rst)
    shot_reg <= SHOT_W'(MAX_SHOTS)) else $error("shot counter above six");
  a_close_dead: assert property (@(posedge clock) disable iff (rst)
    close_reg |-> state_reg == ST_RECLOSING && $past(state_reg) == ST_DEAD && $past(tmr_done))
    else $error("close issued before dead time ended");
  a_block_wins: assert property (@(posedge clock) disable iff (rst)
    (enabled && block_any && !locked) |=> state_reg == ST_BLOCKED)
    else $error("blocking input ignored");
  a_start_ready: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_RUN_FAULT && $past(state_reg) != ST_RUN_FAULT)
    |-> ($past(state_reg) == ST_READY || $past(state_reg) == ST_RUN2READY))
    else $error("run entered from wrong state");
  a_ready_entry: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_READY && $past(state_reg) == ST_MAN_BLOCK)
    |-> $past(tmr_done) && $past(bkr_closed)) else $error("ready before block time");
  a_dead_open: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_DEAD && $past(state_reg) == ST_WAIT_OPEN) |-> !$past(bkr_closed))
    else $error("dead time started with breaker closed");
  a_lor_entry: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_LOR && $past(state_reg) == ST_LOCKOUT) |-> $past(reset_pulse))
    else $error("lockout left without reset");
  a_lor_timer: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_STANDBY && $past(state_reg) == ST_LOR && $past(enabled))
    |-> $past(tmr_done)) else $error("lockout reset timer cut short");
  a_hour_limit: assert property (@(posedge clock) disable iff (rst)
    (hour_reg > $past(hour_reg)) |-> $past(hour_reg) < $past(max_cycles_per_hour))
    else $error("hourly cycle limit exceeded");
  a_tick_gap: assert property (@(posedge clock) disable iff (rst)
    tick |-> ##1 (!tick) [*3]) else $error("tick too frequent");
  a_result_ok: assert property (@(posedge clock) disable iff (rst)
    ok_reg |-> !fail_reg && state_reg == ST_READY && $past(state_reg) == ST_RUN2READY)
    else $error("success flag out of place");
  a_total_count: assert property (@(posedge clock) disable iff (rst)
    close_reg |-> tot_reg == $past(tot_reg) + CNT_W'(1)) else $error("total count missed");
  a_incr_gate: assert property (@(posedge clock) disable iff (rst)
    ($past(state_reg) == ST_DEAD && state_reg == ST_DEAD && !$past(ext_incr_enable))
    |-> shot_reg == $past(shot_reg)) else $error("shot moved with increment disabled");

endmodule
`default_nettype wire

// ==== test/arsq_brk_model.sv ====
// Behavioural circuit breaker facing the auto-reclose sequencer.
`timescale 1ns/1ps
`default_nettype none
module arsq_brk_model #(
  parameter int CLOSE_DLY = 3,
  parameter int OPEN_DLY = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Commands
  input wire logic close_cmd,
  input wire logic manual_close,
  input wire logic trip_open,
  // Position
  output logic breaker_closed,
  output logic breaker_ready
);
  int cls_reg;
  int opn_reg;
  // The spring is not ready again until the close stroke has ended.
  assign breaker_ready = (cls_reg == 0);
  always_ff @(posedge clock) begin
    if (rst) begin
      breaker_closed <= 1'b0;
      cls_reg <= 0;
      opn_reg <= 0;
    end else begin
      opn_reg <= trip_open ? opn_reg + 1 : 0;
      if (close_cmd) begin
        cls_reg <= CLOSE_DLY;
      end else if (cls_reg != 0) begin
        cls_reg <= cls_reg - 1;
      end
      if (trip_open && opn_reg == OPEN_DLY) begin
        breaker_closed <= 1'b0;
      end else if (manual_close || (cls_reg == 1 && !close_cmd)) begin
        breaker_closed <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench for the auto-reclose sequencer core.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import arsq_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  // A short tick keeps millisecond timers to a few cycles each.
  localparam int TDIV = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic function_active = 1'b1;
  logic breaker_configured = 1'b1;
  logic [SHOT_W-1:0] shots_cfg = 3'h1;
  logic [HOUR_W-1:0] max_cycles_per_hour = 8'h0a;
  logic [DT_W-1:0] dead_time_ms [1:MAX_SHOTS];
  logic [3:0] init_sel_idx [0:MAX_SHOTS][0:INIT_SLOTS-1];
  logic [INIT_SLOTS-1:0] init_sel_en [0:MAX_SHOTS];
  logic [15:0] block_func_mask = 16'h0000;
  logic [15:0] prot_trip = 16'h0000;
  logic [1:0] external_block_inputs = 2'h0;
  logic ext_block_enable = 1'b0, ext_lock_enable = 1'b0;
  logic ext_incr_enable = 1'b0, ext_reset_enable = 1'b0;
  logic ext_lock_in = 1'b0, ext_incr_in = 1'b0, ext_reset_in = 1'b0;
  logic manual_close = 1'b0;
  logic [DT_W-1:0] t_manual_block_ms = 16'h0005, t_fault_ms = 16'h0014;
  logic [DT_W-1:0] t_close_sup_ms = 16'h000a, t_run2ready_ms = 16'h0003;
  logic [DT_W-1:0] t_lockout_reset_ms = 16'h0002;
  logic breaker_closed_in, breaker_ready_in, trip_any;
  arsq_state_type state_out;
  logic [SHOT_W-1:0] shot_out;
  logic close_cmd, result_ok, result_fail;
  logic [HOUR_W-1:0] hour_count;
  logic [CNT_W-1:0] count_total, count_ok, count_fail;
  int errors = 0, samples_checked = 0, waited = 0;
  int e_tot = 0, e_ok = 0, e_fail = 0, e_hour = 0;
  assign trip_any = |prot_trip[7:1];
  arsq_core #(.N_FUNC(16), .TICK_DIV(TDIV), .HOUR_LEN_MS(20000)) arsq_core_inst (
    .clock, .rst, .function_active, .breaker_configured, .shots_cfg,
    .max_cycles_per_hour, .dead_time_ms, .t_manual_block_ms, .t_fault_ms,
    .t_close_sup_ms, .t_run2ready_ms, .t_lockout_reset_ms, .init_sel_idx,
    .init_sel_en, .block_func_mask,
    .ext_block_enable, .ext_lock_enable, .ext_incr_enable, .ext_reset_enable,
    .prot_trip, .breaker_closed_in, .breaker_ready_in, .external_block_inputs,
    .ext_lock_in, .ext_incr_in, .ext_reset_in, .state_out, .shot_out, .close_cmd,
    .result_ok, .result_fail, .hour_count, .count_total, .count_ok, .count_fail);
  arsq_brk_model arsq_brk_model_inst (.clock, .rst, .close_cmd, .manual_close,
    .trip_open(trip_any), .breaker_closed(breaker_closed_in),
    .breaker_ready(breaker_ready_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_st(input arsq_state_type st, input int lim);
    waited = 0;
    while (state_out !== st && waited < lim) begin
      @(negedge clock);
      waited++;
    end
    chk("state", state_out, st);
  endtask
  // A timer of ms milliseconds ends at most one tick and one cycle short of its nominal length, and at most two cycles past it.
  function automatic logic [31:0] span_ok(input int n, input int ms);
    return 32'(n >= (ms - 1) * TDIV - 1 && n <= ms * TDIV + 2);
  endfunction
  task automatic pulse(ref logic s);
    s = 1'b1;
    repeat (8) @(negedge clock);
    s = 1'b0;
    repeat (8) @(negedge clock);
  endtask
  task automatic go_ready();
    if (breaker_closed_in !== 1'b1) begin
      manual_close = 1'b1;
      @(negedge clock);
      manual_close = 1'b0;
    end
    wait_st(ST_READY, 100);
  endtask
  task automatic chk_counts();
    chk("total", count_total, e_tot);
    chk("ok count", count_ok, e_ok);
    chk("fail count", count_fail, e_fail);
    chk("hour count", hour_count, e_hour);
  endtask
  task automatic reclose(input int s);
    int n;
    n = 0;
    while (close_cmd !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    chk("close", close_cmd, 1);
    chk("shot", shot_out, s);
    chk("dead span", span_ok(n, 3 * s), 1);
  endtask
  task automatic unlock();
    ext_reset_enable = 1'b0;
    pulse(ext_reset_in);
    chk("state", state_out, ST_LOCKOUT);
    ext_reset_enable = 1'b1;
    ext_reset_in = 1'b1;
    wait_st(ST_LOR, 10);
    ext_reset_in = 1'b0;
    wait_st(ST_STANDBY, 30);
    chk("reset span", span_ok(waited, 2), 1);
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_manual();
    chk("state", state_out, ST_STANDBY);
    go_ready();
    chk("block span", span_ok(waited - 5, 5), 1);
  endtask
  task automatic t_success();
    go_ready();
    prot_trip[1] = 1'b1;
    wait_st(ST_DEAD, 100);
    prot_trip = 16'h0000;
    reclose(1);
    wait_st(ST_READY, 200);
    chk("ok pulse", result_ok, 1);
    chk("shot", shot_out, 0);
    e_tot++;
    e_ok++;
    e_hour++;
    chk_counts();
  endtask
  task automatic t_fail();
    shots_cfg = 3'h2;
    go_ready();
    prot_trip[1] = 1'b1;
    for (int s = 1; s <= 2; s++) begin
      wait_st(ST_DEAD, 100);
      prot_trip = 16'h0000;
      reclose(s);
      wait_st(ST_RUN2READY, 50);
      prot_trip[s + 1] = 1'b1;
    end
    wait_st(ST_LOCKOUT, 100);
    chk("fail pulse", result_fail, 1);
    prot_trip = 16'h0000;
    e_tot += 2;
    e_fail++;
    e_hour++;
    chk_counts();
    unlock();
  endtask
  task automatic t_hour();
    max_cycles_per_hour = 8'(e_hour);
    go_ready();
    prot_trip[1] = 1'b1;
    wait_st(ST_LOCKOUT, 10);
    prot_trip = 16'h0000;
    chk_counts();
    max_cycles_per_hour = 8'h0a;
    unlock();
  endtask
  task automatic t_block();
    go_ready();
    prot_trip[15] = 1'b1;
    repeat (10) @(negedge clock);
    chk("state", state_out, ST_READY);
    block_func_mask = 16'h8000;
    wait_st(ST_BLOCKED, 3);
    prot_trip = 16'h0000;
    go_ready();
    external_block_inputs = 2'h2;
    repeat (10) @(negedge clock);
    chk("state", state_out, ST_READY);
    ext_block_enable = 1'b1;
    wait_st(ST_BLOCKED, 8);
    external_block_inputs = 2'h0;
    go_ready();
    ext_lock_in = 1'b1;
    repeat (10) @(negedge clock);
    chk("state", state_out, ST_READY);
    ext_lock_enable = 1'b1;
    wait_st(ST_LOCKOUT, 8);
    ext_lock_in = 1'b0;
    unlock();
  endtask
  // A one-cycle initiate starts the run but never confirms it, so the fault timer ends it.
  task automatic t_fault();
    t_fault_ms = 16'h0003;
    go_ready();
    prot_trip[1] = 1'b1;
    @(negedge clock);
    prot_trip = 16'h0000;
    wait_st(ST_LOCKOUT, 50);
    chk("fault span", span_ok(waited, 3), 1);
    chk("fail pulse", result_fail, 1);
    e_fail++;
    e_hour++;
    chk_counts();
    unlock();
  endtask
  task automatic t_disable();
    for (int k = 0; k < 2; k++) begin
      go_ready();
      function_active = (k != 0);
      breaker_configured = (k == 0);
      wait_st(ST_STANDBY, 3);
      prot_trip[1] = 1'b1;
      repeat (10) @(negedge clock);
      chk("state", state_out, ST_STANDBY);
      prot_trip = 16'h0000;
      function_active = 1'b1;
      breaker_configured = 1'b1;
    end
  endtask
  task automatic t_incr();
    go_ready();
    pulse(ext_incr_in);
    chk("shot", shot_out, 0);
    ext_incr_enable = 1'b1;
    pulse(ext_incr_in);
    chk("shot", shot_out, 1);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    e_tot = 0;
    e_ok = 0;
    e_fail = 0;
    e_hour = 0;
    @(negedge clock);
    chk("state", state_out, ST_STANDBY);
    chk("shot", shot_out, 0);
    chk_counts();
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    $display("ERROR watchdog expected end seen timeout");
    end_sim();
  end
  initial begin
    for (int s = 0; s <= MAX_SHOTS; s++) begin
      init_sel_en[s] = 4'h1;
      for (int k = 0; k < INIT_SLOTS; k++) begin
        init_sel_idx[s][k] = 4'(s + 1);
      end
      if (s > 0) begin
        dead_time_ms[s] = 16'(3 * s);
      end
    end
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk_counts();
    t_manual();
    t_success();
    t_fail();
    t_hour();
    t_block();
    t_fault();
    t_disable();
    t_incr();
    end_sim();
  end
endmodule
`default_nettype wire
